// ### verilog/rxtsp_defs.vh
// Constants for the receive packet stream port
`ifndef RXTSP_DEFS_VH
`define RXTSP_DEFS_VH
`define RXTSP_DATA_W 128
`define RXTSP_QDEPTH 16
`define RXTSP_QPTR_W 4
`define RXTSP_TYPE_POSTED 2'h0
`define RXTSP_TYPE_NONPOSTED 2'h1
`define RXTSP_TYPE_COMPLETION 2'h2
`define RXTSP_REM_RESET 2'h0
`define RXTSP_LANE_HI 1'h1
`endif

// ### verilog/rxtsp_queue.v
// Single-packet-class word queue feeding the stream port
`timescale 1ns/1ps
`include "rxtsp_defs.vh"
module rxtsp_queue (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Fill side
    input wire in_valid,
    input wire [`RXTSP_DATA_W+3:0] in_word,
    output wire in_ready,
    // Drain side
    output wire out_valid,
    output wire [`RXTSP_DATA_W+3:0] out_word,
    input wire out_take
);
    reg [`RXTSP_DATA_W+3:0] mem [0:`RXTSP_QDEPTH-1];
    reg [`RXTSP_QPTR_W:0] wr_ptr;
    reg [`RXTSP_QPTR_W:0] rd_ptr;
    wire full;
    wire empty;

    // Honest full and empty from extended pointers
    assign empty = (wr_ptr == rd_ptr);
    assign full = (wr_ptr[`RXTSP_QPTR_W] != rd_ptr[`RXTSP_QPTR_W]) &&
        (wr_ptr[`RXTSP_QPTR_W-1:0] == rd_ptr[`RXTSP_QPTR_W-1:0]);
    assign in_ready = ~full;
    assign out_valid = ~empty;
    assign out_word = mem[rd_ptr[`RXTSP_QPTR_W-1:0]];

    // Storage write
    always @(posedge mclk) begin
        if (in_valid && !full) begin
            mem[wr_ptr[`RXTSP_QPTR_W-1:0]] <= in_word;
        end
    end

    // Pointer update
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= {(`RXTSP_QPTR_W+1){1'b0}};
            rd_ptr <= {(`RXTSP_QPTR_W+1){1'b0}};
        end else begin
            if (in_valid && !full) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (out_take && !empty) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

// ### verilog/rxtsp_port.v
// Receive packet stream port: arbitration, framing and abort toward user logic
// What this block does
// - With acceptance withheld and no pull pending, posted and completion packets overtake queued non-posted ones.
// - Each pull request pulse releases exactly one non-posted packet, with up to 15 pulses pending.
// - Remainder meaningful only with end-of-frame and source valid; upper bit for 128 bits.
// - 64-bit: remainder low 1 means data on 63:0, 0 means 63:32.
// - 128-bit: upper bit 1 means start in 127:64 and/or end in 63:0.
// - 128-bit: low bit valid at end beat; selects 127:32 or 127:64.
// - Start-of-frame flag marks each packet's first beat.
// - Source abort tells the user the current packet is abandoned.
// - Source abort rises when the physical link enters reset during a packet or while a word is still held.
// - Source valid high only when the payload bus carries packet data.
// - A beat transfers only when source valid and sink ready are both high.
// - End-of-frame flag marks each packet's last beat.
`timescale 1ns/1ps
`include "rxtsp_defs.vh"
module rxtsp_port #(
    parameter WIDE = 1
) (
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Inbound packet words from the transaction layer
    input wire in_valid,
    input wire [`RXTSP_DATA_W-1:0] in_data,
    input wire in_first,
    input wire in_last,
    input wire [1:0] in_rem,
    input wire [1:0] in_type,
    output wire in_ready,
    // Physical link reset indication, asynchronous
    input wire link_reset,
    // User flow controls
    input wire rx_nonposted_accept_ok,
    input wire rx_nonposted_pull_request,
    input wire rx_sink_ready,
    // User stream
    output reg [`RXTSP_DATA_W-1:0] rx_payload_bus,
    output reg rx_frame_first,
    output reg rx_frame_last,
    output reg [1:0] rx_word_remainder,
    output reg rx_source_valid,
    output reg rx_source_abort
);
    localparam ST_IDLE = 2'h0;
    localparam ST_PKT = 2'h1;
    localparam ST_ABORT = 2'h2;

    reg rst_a;
    reg rst_n;
    reg lr1;
    reg lr2;
    reg lr3;
    reg link_rst;
    reg [1:0] state;
    reg [1:0] next_state;
    reg sel_np;
    reg next_sel_np;
    reg [3:0] pull_credit;
    reg pull_prev;
    wire pull_pulse;
    wire is_np;
    wire p_in_ready;
    wire np_in_ready;
    wire p_valid;
    wire np_valid;
    wire [`RXTSP_DATA_W+3:0] p_word;
    wire [`RXTSP_DATA_W+3:0] np_word;
    wire [`RXTSP_DATA_W+3:0] cur_word;
    wire cur_valid;
    wire out_free;
    wire take;
    wire take_p;
    wire take_np;
    wire np_gate;

    // Decode of a packed word's end flag
    function word_last;
        input [`RXTSP_DATA_W+3:0] w;
        begin
            word_last = w[`RXTSP_DATA_W+2];
        end
    endfunction

    // ------------------------------------------------
    // Reset release and link reset synchroniser
    // ------------------------------------------------
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_a <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_a <= 1'b1;
            rst_n <= rst_a;
        end
    end

    // Three stages; a change counts when the last two agree
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lr1 <= 1'b0;
            lr2 <= 1'b0;
            lr3 <= 1'b0;
            link_rst <= 1'b0;
        end else begin
            lr1 <= link_reset;
            lr2 <= lr1;
            lr3 <= lr2;
            if (lr2 == lr3) begin
                link_rst <= lr3;
            end
        end
    end

    // ------------------------------------------------
    // Class queues: posted/completion and non-posted
    // ------------------------------------------------
    assign is_np = (in_type == `RXTSP_TYPE_NONPOSTED);
    assign in_ready = (is_np ? np_in_ready : p_in_ready) & ~link_rst;

    rxtsp_queue u_pq (
        .mclk(mclk),
        .rst_n(rst_n),
        .in_valid(in_valid & ~is_np & ~link_rst),
        .in_word({in_first, in_last, in_rem, in_data}),
        .in_ready(p_in_ready),
        .out_valid(p_valid),
        .out_word(p_word),
        .out_take(take_p)
    );

    // Held here untouched while acceptance is withheld and no pull is pending
    rxtsp_queue u_npq (
        .mclk(mclk),
        .rst_n(rst_n),
        .in_valid(in_valid & is_np & ~link_rst),
        .in_word({in_first, in_last, in_rem, in_data}),
        .in_ready(np_in_ready),
        .out_valid(np_valid),
        .out_word(np_word),
        .out_take(take_np)
    );

    // ------------------------------------------------
    // Pull requests: one credit per rising request, up to 15 pending
    // ------------------------------------------------
    assign pull_pulse = rx_nonposted_pull_request & ~pull_prev;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pull_prev <= 1'b0;
            pull_credit <= 4'h0;
        end else begin
            pull_prev <= rx_nonposted_pull_request;
            if (link_rst) begin
                pull_credit <= 4'h0;
            end else if (pull_pulse && !(take_np && word_last(np_word))) begin
                if (pull_credit != 4'hf) begin
                    pull_credit <= pull_credit + 4'h1;
                end
            end else if (!pull_pulse && take_np && word_last(np_word) &&
                    pull_credit != 4'h0) begin
                pull_credit <= pull_credit - 4'h1;
            end
        end
    end

    // Non-posted start allowed by accept level or a pending pull
    assign np_gate = rx_nonposted_accept_ok | (pull_credit != 4'h0);

    // ------------------------------------------------
    // Packet arbitration, whole packets only
    // ------------------------------------------------
    always @* begin
        next_state = state;
        next_sel_np = sel_np;
        case (state)
            ST_IDLE: begin
                if (link_rst) begin
                    next_state = ST_ABORT;
                end else if (np_valid && np_gate) begin
                    next_sel_np = 1'b1;
                    next_state = ST_PKT;
                end else if (p_valid) begin
                    next_sel_np = 1'b0;
                    next_state = ST_PKT;
                end
            end
            ST_PKT: begin
                if (link_rst) begin
                    next_state = ST_ABORT;
                end else if (take && word_last(cur_word)) begin
                    next_state = ST_IDLE;
                end
            end
            ST_ABORT: begin
                if (!link_rst) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    assign cur_word = sel_np ? np_word : p_word;
    assign cur_valid = sel_np ? np_valid : p_valid;
    // Output register free when empty or being consumed
    assign out_free = ~rx_source_valid | rx_sink_ready;
    assign take = (state == ST_PKT) & ~link_rst & cur_valid & out_free;
    assign take_p = take & ~sel_np;
    assign take_np = take & sel_np;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            sel_np <= 1'b0;
        end else begin
            state <= next_state;
            sel_np <= next_sel_np;
        end
    end

    // ------------------------------------------------
    // Output stage toward user logic
    // ------------------------------------------------
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_payload_bus <= {`RXTSP_DATA_W{1'b0}};
            rx_frame_first <= 1'b0;
            rx_frame_last <= 1'b0;
            rx_word_remainder <= `RXTSP_REM_RESET;
            rx_source_valid <= 1'b0;
            rx_source_abort <= 1'b0;
        end else begin
            // Abort also covers a held word of a frame not yet handed over
            rx_source_abort <= link_rst &
                ((state == ST_PKT) | ((state == ST_IDLE) & rx_source_valid));
            if (link_rst) begin
                rx_source_valid <= 1'b0;
            end else if (take) begin
                rx_source_valid <= 1'b1;
                rx_payload_bus <= cur_word[`RXTSP_DATA_W-1:0];
                rx_frame_first <= cur_word[`RXTSP_DATA_W+3];
                rx_frame_last <= cur_word[`RXTSP_DATA_W+2];
                // Upper bit only on the wide path; low bit as framed
                rx_word_remainder <= {(WIDE != 0) & cur_word[`RXTSP_DATA_W+1],
                    cur_word[`RXTSP_DATA_W]};
            end else if (rx_sink_ready) begin
                rx_source_valid <= 1'b0;
            end
        end
    end
endmodule

// ### sim/rxtsp_props.sv
// Checker for the receive packet stream port
`timescale 1ns/1ps
`include "rxtsp_defs.vh"
module rxtsp_props (
    // Clock, reset and link reset
    input wire mclk,
    input wire reset_n,
    input wire link_reset,
    // Inbound handshake
    input wire in_valid,
    input wire in_ready,
    // User stream
    input wire rx_sink_ready,
    input wire [`RXTSP_DATA_W-1:0] rx_payload_bus,
    input wire rx_frame_first,
    input wire rx_frame_last,
    input wire rx_source_valid,
    input wire rx_source_abort
);
    reg [4:0] hist;
    reg open;
    reg [7:0] occ;
    wire quiet = hist == 5'h00 && !link_reset;
    wire beat = rx_source_valid && rx_sink_ready;
    sequence s_beat_held;
        rx_source_valid && $stable(rx_payload_bus);
    endsequence
    // Link history, open frame and words still owed
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hist <= 5'h00;
            open <= 1'b0;
            occ <= 8'h00;
        end else begin
            hist <= {hist[3:0], link_reset};
            open <= rx_source_abort ? 1'b0 : beat ? !rx_frame_last : open;
            occ <= occ + {7'h00, in_valid && in_ready} - {7'h00, beat};
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_beat_holds: assert property (quiet && rx_source_valid && !rx_sink_ready |=> s_beat_held)
        else $error("beat not held");
    a_valid_has_word: assert property (rx_source_valid |-> occ != 8'h00)
        else $error("valid without word");
    a_first_closed: assert property (quiet && rx_source_valid && rx_frame_first |-> !open)
        else $error("start inside frame");
    a_mid_open: assert property (quiet && rx_source_valid && !rx_frame_first |-> open)
        else $error("beat outside frame");
    a_abort_link: assert property ($rose(link_reset) && open |-> ##[2:8] rx_source_abort)
        else $error("no abort");
    a_abort_cause: assert property (rx_source_abort |-> hist != 5'h00 || link_reset)
        else $error("abort without link reset");
    a_valid_off: assert property (hist == 5'h1f |-> !rx_source_valid)
        else $error("valid during link reset");
    a_inbound_shut: assert property (hist == 5'h1f |-> !in_ready)
        else $error("ready during link reset");
endmodule
bind rxtsp_port rxtsp_props u_props (.mclk(mclk), .reset_n(reset_n), .link_reset(link_reset),
    .in_valid(in_valid), .in_ready(in_ready), .rx_sink_ready(rx_sink_ready),
    .rx_payload_bus(rx_payload_bus), .rx_frame_first(rx_frame_first),
    .rx_frame_last(rx_frame_last), .rx_source_valid(rx_source_valid),
    .rx_source_abort(rx_source_abort));

// ### sim/rxtsp_user_model.sv
// User-side consumer model for the receive stream
`timescale 1ns/1ps
module rxtsp_user_model (
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Bench controls
    input wire slow,
    input wire np_ok,
    input wire pull,
    // Controls toward the port
    output reg rx_sink_ready,
    output reg rx_nonposted_accept_ok,
    output reg rx_nonposted_pull_request
);
    // Ready every cycle, or every other cycle when slow
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rx_sink_ready <= 1'b0;
            rx_nonposted_accept_ok <= 1'b0;
            rx_nonposted_pull_request <= 1'b0;
        end else begin
            rx_sink_ready <= slow ? !rx_sink_ready : 1'b1;
            rx_nonposted_accept_ok <= np_ok;
            rx_nonposted_pull_request <= pull;
        end
    end
endmodule

// ### sim/tb_rxtsp_port.sv
// Self-checking bench for the receive packet stream port
`timescale 1ns/1ps
`include "rxtsp_defs.vh"
module tb_rxtsp_port;
    reg mclk = 1'b0;
    reg reset_n = 1'b0;
    reg in_valid = 1'b0, in_first = 1'b0, in_last = 1'b0, link_reset = 1'b0;
    reg [127:0] in_data = 128'h0;
    reg [1:0] in_rem = 2'h0, in_type = 2'h0;
    reg slow = 1'b0, np_ok = 1'b1, pull = 1'b0, saw_abort = 1'b0;
    wire in_ready, sink_rdy, np_acc, np_pull, valid, first, last, abort;
    wire [1:0] rem;
    wire [127:0] data;
    integer n_mismatch = 0, total_checks = 0, cyc = 0;
    reg [11:0] beats [$];
    reg [1:0] nrem [$];
    wire [1:0] rem_narrow;
    rxtsp_port #(.WIDE(1)) uut (.mclk(mclk), .reset_n(reset_n), .in_valid(in_valid),
        .in_data(in_data), .in_first(in_first), .in_last(in_last), .in_rem(in_rem),
        .in_type(in_type), .in_ready(in_ready), .link_reset(link_reset),
        .rx_nonposted_accept_ok(np_acc), .rx_nonposted_pull_request(np_pull),
        .rx_sink_ready(sink_rdy), .rx_payload_bus(data), .rx_frame_first(first),
        .rx_frame_last(last), .rx_word_remainder(rem), .rx_source_valid(valid),
        .rx_source_abort(abort));
    rxtsp_user_model u_user (.mclk(mclk), .reset_n(reset_n), .slow(slow), .np_ok(np_ok),
        .pull(pull), .rx_sink_ready(sink_rdy), .rx_nonposted_accept_ok(np_acc),
        .rx_nonposted_pull_request(np_pull));
    // Narrow-path copy, run in lockstep, only its remainder is judged
    rxtsp_port #(.WIDE(0)) uut_narrow (.mclk(mclk), .reset_n(reset_n), .in_valid(in_valid),
        .in_data(in_data), .in_first(in_first), .in_last(in_last), .in_rem(in_rem),
        .in_type(in_type), .in_ready(), .link_reset(link_reset),
        .rx_nonposted_accept_ok(np_acc), .rx_nonposted_pull_request(np_pull),
        .rx_sink_ready(sink_rdy), .rx_payload_bus(), .rx_frame_first(),
        .rx_frame_last(), .rx_word_remainder(rem_narrow), .rx_source_valid(),
        .rx_source_abort());
    // Clock
    initial forever #2 mclk = ~mclk;
    // Beat capture and hang limit
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (valid && sink_rdy) begin
            beats.push_back({data[7:0], first, last, rem & {2{last}}});
            nrem.push_back(rem_narrow & {2{last}});
        end
        if (abort) saw_abort = 1'b1;
        if (cyc == 6000) begin
            n_mismatch = n_mismatch + 1;
            print_verdict;
        end
    end
    task check(input [11:0] got, input [11:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task send(input [1:0] t, input [7:0] id, input f, input l, input [1:0] r);
        integer k;
        in_valid = 1'b1;
        in_data = {120'h0, id};
        in_first = f;
        in_last = l;
        in_rem = r;
        in_type = t;
        // Word is taken at the first edge that samples in_ready high
        @(posedge mclk);
        for (k = 0; k < 200 && !in_ready; k = k + 1) begin
            @(posedge mclk);
        end
        if (!in_ready) n_mismatch = n_mismatch + 1;
        #1;
    endtask
    task wait_beats(input integer n);
        integer k;
        for (k = 0; k < 300 && beats.size() < n; k = k + 1) @(posedge mclk);
        @(posedge mclk);
        #1;
        if (beats.size() < n) n_mismatch = n_mismatch + 1;
    endtask
    task t_framing;
        slow = 1'b1;
        send(`RXTSP_TYPE_POSTED, 8'h11, 1'b1, 1'b1, 2'h3);
        send(`RXTSP_TYPE_COMPLETION, 8'h12, 1'b1, 1'b0, 2'h0);
        send(`RXTSP_TYPE_COMPLETION, 8'h13, 1'b0, 1'b0, 2'h0);
        send(`RXTSP_TYPE_COMPLETION, 8'h14, 1'b0, 1'b1, 2'h2);
        in_valid = 1'b0;
        wait_beats(4);
        check(beats.pop_front(), {8'h11, 4'hf});
        check(beats.pop_front(), {8'h12, 4'h8});
        check(beats.pop_front(), {8'h13, 4'h0});
        check(beats.pop_front(), {8'h14, 4'h6});
        check({10'h0, nrem[0]}, 12'h1);
        check({10'h0, nrem[3]}, 12'h0);
        nrem.delete();
        slow = 1'b0;
        $display("test framing done");
    endtask
    task t_bypass;
        np_ok = 1'b0;
        send(`RXTSP_TYPE_NONPOSTED, 8'h21, 1'b1, 1'b1, 2'h1);
        send(`RXTSP_TYPE_NONPOSTED, 8'h23, 1'b1, 1'b1, 2'h1);
        send(`RXTSP_TYPE_POSTED, 8'h22, 1'b1, 1'b1, 2'h1);
        in_valid = 1'b0;
        wait_beats(1);
        repeat (20) @(posedge mclk);
        #1;
        check(12'(beats.size()), 12'h1);
        check(beats.pop_front(), {8'h22, 4'hd});
        pull = 1'b1;
        @(posedge mclk);
        #1;
        pull = 1'b0;
        wait_beats(1);
        repeat (20) @(posedge mclk);
        #1;
        check(12'(beats.size()), 12'h1);
        check(beats.pop_front(), {8'h21, 4'hd});
        np_ok = 1'b1;
        wait_beats(1);
        check(beats.pop_front(), {8'h23, 4'hd});
        $display("test bypass done");
    endtask
    task t_abort;
        send(`RXTSP_TYPE_COMPLETION, 8'h31, 1'b1, 1'b0, 2'h0);
        in_valid = 1'b0;
        wait_beats(1);
        link_reset = 1'b1;
        repeat (12) @(posedge mclk);
        #1;
        check({11'h0, valid}, 12'h0);
        check({11'h0, saw_abort}, 12'h1);
        check({11'h0, in_ready}, 12'h0);
        link_reset = 1'b0;
        repeat (8) @(posedge mclk);
        #1;
        check(beats.pop_front(), {8'h31, 4'h8});
        send(`RXTSP_TYPE_POSTED, 8'h41, 1'b1, 1'b1, 2'h3);
        in_valid = 1'b0;
        wait_beats(1);
        check(beats.pop_front(), {8'h41, 4'hf});
        $display("test abort done");
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge mclk);
        #1;
        reset_n = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        t_framing;
        t_bypass;
        t_abort;
        print_verdict;
    end
endmodule
